// >>> usart_rx_consts.svh
// What this block does
// - Sample the line at sixteen times bit rate
// - Accept frames only while continuous receive set
// - Stop bit sampled: move word into FIFO
// - Word pushed: set receive-ready flag
// - Interrupt request gated by receive interrupt enable bit
// - Ready flag read-only, clears when FIFO empty
// - Receive FIFO holds two entries
// - Full at third stop bit: overrun, drop
// - Overrun clears only by toggling continuous receive
// - Overrun blocks every FIFO push
// - Low stop bit sets framing error
// - Framing and ninth bit stored per entry
// - Nine data bits when nine-bit select set
// - Synchronous master mode is half duplex
// - Sync select and port enable assign pins
// - Clock source set drives shift clock out
// - Unimplemented status bits read as zero
// - Start, eight or nine data, stop, LSB first
// - Majority of samples seven, eight, nine
// - Baud generator runs at x16 or x64
`ifndef USART_RX_CONSTS_SVH
`define USART_RX_CONSTS_SVH

`define IDX_IRQ_FLAGS        8'h0C
`define IDX_RX_STATUS        8'h18
`define IDX_TX_BUFFER        8'h19
`define IDX_RX_BUFFER        8'h1A
`define IDX_IRQ_ENABLES      8'h8C
`define IDX_TX_STATUS        8'h98
`define IDX_BAUD_DIVISOR     8'h99

`define RST_IRQ_FLAGS        8'h00
`define RST_RX_STATUS        8'h00
`define RST_TX_BUFFER        8'h00
`define RST_IRQ_ENABLES      8'h00
`define RST_TX_STATUS        8'h02
`define RST_BAUD_DIVISOR     8'h00

`define BIT_RX_READY         5
`define BIT_RX_IRQ_ENABLE    5
`define BIT_PORT_ENABLE      7
`define BIT_NINE_SELECT      6
`define BIT_SINGLE_RX        5
`define BIT_CONT_RX          4
`define BIT_FRAMING          2
`define BIT_OVERRUN          1
`define BIT_NINTH            0
`define BIT_CLOCK_SOURCE     7
`define BIT_TX_ENABLE        5
`define BIT_SYNC_SELECT      4
`define BIT_HIGH_BAUD        2
`define BIT_TX_EMPTY         1

`define SAMPLE_FIRST         4'h6
`define SAMPLE_SECOND        4'h7
`define SAMPLE_THIRD         4'h8
`define LOW_BAUD_PRESCALE    2'h3
`define FIFO_DEPTH           2'h2

`endif

// >>> usart_rx_pkg.sv
`default_nettype none
package usart_rx_pkg;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_t;
endpackage
`default_nettype wire

// >>> rx_bit_sampler.sv
`include "usart_rx_consts.svh"
`default_nettype none
module rx_bit_sampler (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	input  wire logic tick,
	input  wire logic restart,
	input  wire logic rx_in,
	output var  logic bit_done,
	output var  logic bit_value
);
	logic [3:0] phase;
	logic       first;
	logic       second;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 4'h0;
			first <= 1'b1;
			second <= 1'b1;
			bit_done <= 1'b0;
			bit_value <= 1'b1;
		end else if (ce) begin
			bit_done <= 1'b0;
			if (restart) begin
				phase <= 4'h0;
			end else if (tick) begin
				phase <= phase + 4'h1;
				if (phase == `SAMPLE_FIRST) first <= rx_in;
				if (phase == `SAMPLE_SECOND) second <= rx_in;
				if (phase == `SAMPLE_THIRD) begin
					bit_done <= 1'b1;
					bit_value <= (first & second) | (first & rx_in) | (second & rx_in);
				end
			end
		end
	end

	AST_DONE_AFTER_THIRD: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(bit_done) |-> $past(phase) == `SAMPLE_THIRD)
		else $error("bit decided off the third sample");
endmodule
`default_nettype wire

// >>> usart_async_receiver.sv
// Decided for this implementation: the AXI4-Lite slave port.
`include "usart_rx_consts.svh"
`default_nettype none
module usart_async_receiver (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        serial_data_line_in,
	output var  logic        shift_clock_line_out,
	output var  logic        shift_clock_line_oe,
	output var  logic        transmit_hold,
	output var  logic        receive_irq
);
	logic [7:0]  irq_enables;
	logic [7:0]  transmit_buffer;
	logic [7:0]  baud_rate_divisor;
	logic        serial_port_enable;
	logic        nine_bit_receive_select;
	logic        single_receive_enable;
	logic        continuous_receive_enable;
	logic        clock_source_master_select;
	logic        tx9_select;
	logic        tx_enable;
	logic        sync_select;
	logic        high_baud_select;
	logic        tx9_data;
	logic        overrun_error_flag;
	logic        receive_ready_flag;
	logic [9:0]  fifo_mem [2];
	logic        wr_ptr;
	logic        rd_ptr;
	logic [1:0]  fifo_count;
	logic [7:0]  brg_count;
	logic        brg_tick;
	logic [1:0]  prescale;
	logic        tick16;
	logic        rx_meta;
	logic        rx_sync;
	logic        rx_prev;
	usart_rx_pkg::rx_state_t rx_state;
	logic [8:0]  receive_shifter;
	logic [3:0]  bit_index;
	logic        bit_done;
	logic        bit_value;
	logic        restart;
	logic        rx_enable;
	logic        stop_done;
	logic        push;
	logic        pop;
	logic        wr_go;
	logic        rd_go;
	logic [7:0]  wr_byte;
	logic [7:0]  rd_byte;
	logic        rd_hit;
	logic        wr_hit;
	logic [1:0]  next_fifo_count;

	assign rx_enable = serial_port_enable & continuous_receive_enable & ~sync_select;
	assign stop_done = rx_enable && (rx_state == usart_rx_pkg::RX_STOP) && bit_done;
	assign push      = stop_done && !overrun_error_flag && fifo_count != `FIFO_DEPTH;
	assign wr_go     = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign rd_go     = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	assign wr_byte   = s_axi_wdata[7:0];
	assign wr_hit    = s_axi_awaddr[11:10] == 2'h0 && s_axi_wstrb[0];
	assign pop       = rd_go && rd_hit && s_axi_araddr[9:2] == `IDX_RX_BUFFER && fifo_count != 2'h0;
	assign next_fifo_count = fifo_count + {1'b0, push} - {1'b0, pop};
	assign restart   = rx_state == usart_rx_pkg::RX_IDLE;

	// Register reads
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = s_axi_araddr[11:10] == 2'h0;
		unique case (s_axi_araddr[9:2])
			`IDX_IRQ_FLAGS:    rd_byte[`BIT_RX_READY] = receive_ready_flag;
			`IDX_RX_STATUS:    rd_byte = {serial_port_enable, nine_bit_receive_select,
				single_receive_enable, continuous_receive_enable, 1'b0,
				fifo_mem[rd_ptr][9], overrun_error_flag, fifo_mem[rd_ptr][8]};
			`IDX_TX_BUFFER:    rd_byte = transmit_buffer;
			`IDX_RX_BUFFER:    rd_byte = fifo_mem[rd_ptr][7:0];
			`IDX_IRQ_ENABLES:  rd_byte = irq_enables;
			`IDX_TX_STATUS:    rd_byte = {clock_source_master_select, tx9_select, tx_enable,
				sync_select, 1'b0, high_baud_select, 1'b1, tx9_data};
			`IDX_BAUD_DIVISOR: rd_byte = baud_rate_divisor;
			default:           rd_hit = 1'b0;
		endcase
	end

	// Write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (ce) begin
			s_axi_awready <= wr_go;
			s_axi_wready <= wr_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr[11:10] == 2'h0) ? 2'h0 : 2'h3;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			s_axi_arready <= rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Software-written configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enables <= `RST_IRQ_ENABLES;
			transmit_buffer <= `RST_TX_BUFFER;
			baud_rate_divisor <= `RST_BAUD_DIVISOR;
			{serial_port_enable, nine_bit_receive_select, single_receive_enable,
				continuous_receive_enable} <= 4'(`RST_RX_STATUS >> 4);
			{clock_source_master_select, tx9_select, tx_enable,
				sync_select} <= 4'(`RST_TX_STATUS >> 4);
			high_baud_select <= 1'(`RST_TX_STATUS >> `BIT_HIGH_BAUD);
			tx9_data <= 1'(`RST_TX_STATUS);
		end else if (ce && wr_go && wr_hit) begin
			unique case (s_axi_awaddr[9:2])
				`IDX_TX_BUFFER:    transmit_buffer <= wr_byte;
				`IDX_IRQ_ENABLES:  irq_enables <= wr_byte;
				`IDX_BAUD_DIVISOR: baud_rate_divisor <= wr_byte;
				`IDX_RX_STATUS: begin
					serial_port_enable <= wr_byte[`BIT_PORT_ENABLE];
					nine_bit_receive_select <= wr_byte[`BIT_NINE_SELECT];
					single_receive_enable <= wr_byte[`BIT_SINGLE_RX];
					continuous_receive_enable <= wr_byte[`BIT_CONT_RX];
				end
				`IDX_TX_STATUS: begin
					clock_source_master_select <= wr_byte[`BIT_CLOCK_SOURCE];
					tx9_select <= wr_byte[6];
					tx_enable <= wr_byte[`BIT_TX_ENABLE];
					sync_select <= wr_byte[`BIT_SYNC_SELECT];
					high_baud_select <= wr_byte[`BIT_HIGH_BAUD];
					tx9_data <= wr_byte[0];
				end
				default: ;
			endcase
		end
	end

	// Shared baud generator and x16 sample tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			brg_count <= 8'h00;
			brg_tick <= 1'b0;
			prescale <= 2'h0;
		end else if (ce) begin
			brg_tick <= 1'b0;
			if (!serial_port_enable) begin
				brg_count <= baud_rate_divisor;
				prescale <= 2'h0;
			end else if (brg_count == 8'h00) begin
				brg_count <= baud_rate_divisor;
				brg_tick <= 1'b1;
			end else begin
				brg_count <= brg_count - 8'h01;
			end
			if (brg_tick) prescale <= prescale + 2'h1;
		end
	end

	assign tick16 = brg_tick && (high_baud_select || prescale == `LOW_BAUD_PRESCALE);

	// Line synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else if (ce) begin
			rx_meta <= serial_data_line_in;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	rx_bit_sampler u_sampler (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.tick      (tick16),
		.restart   (restart),
		.rx_in     (rx_sync),
		.bit_done  (bit_done),
		.bit_value (bit_value)
	);

	// Frame sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state <= usart_rx_pkg::RX_IDLE;
			receive_shifter <= 9'h000;
			bit_index <= 4'h0;
		end else if (ce) begin
			if (!rx_enable) begin
				rx_state <= usart_rx_pkg::RX_IDLE;
			end else begin
				unique case (rx_state)
					usart_rx_pkg::RX_IDLE: begin
						bit_index <= 4'h0;
						if (rx_prev && !rx_sync) rx_state <= usart_rx_pkg::RX_START;
					end
					usart_rx_pkg::RX_START: begin
						if (bit_done) begin
							receive_shifter <= 9'h000;
							rx_state <= bit_value ? usart_rx_pkg::RX_IDLE
								: usart_rx_pkg::RX_DATA;
						end
					end
					usart_rx_pkg::RX_DATA: begin
						if (bit_done) begin
							receive_shifter[bit_index] <= bit_value;
							bit_index <= bit_index + 4'h1;
							if (bit_index == (nine_bit_receive_select ? 4'h8 : 4'h7))
								rx_state <= usart_rx_pkg::RX_STOP;
						end
					end
					usart_rx_pkg::RX_STOP: begin
						if (bit_done) rx_state <= usart_rx_pkg::RX_IDLE;
					end
				endcase
			end
		end
	end

	// Receive FIFO, flags and overrun
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_mem[0] <= 10'h000;
			fifo_mem[1] <= 10'h000;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fifo_count <= 2'h0;
			overrun_error_flag <= 1'b0;
			receive_ready_flag <= 1'(`RST_IRQ_FLAGS >> `BIT_RX_READY);
			receive_irq <= 1'b0;
		end else if (ce) begin
			if (push) begin
				fifo_mem[wr_ptr] <= {~bit_value, receive_shifter};
				wr_ptr <= ~wr_ptr;
			end
			if (pop) rd_ptr <= ~rd_ptr;
			fifo_count <= next_fifo_count;
			receive_ready_flag <= next_fifo_count != 2'h0;
			receive_irq <= next_fifo_count != 2'h0 && irq_enables[`BIT_RX_IRQ_ENABLE];
			if (!continuous_receive_enable)
				overrun_error_flag <= 1'b0;
			else if (stop_done && fifo_count == `FIFO_DEPTH)
				overrun_error_flag <= 1'b1;
		end
	end

	// Synchronous master pin assignment
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_clock_line_out <= 1'b0;
			shift_clock_line_oe <= 1'b0;
			transmit_hold <= 1'b0;
		end else if (ce) begin
			shift_clock_line_oe <= serial_port_enable & sync_select & clock_source_master_select;
			if (shift_clock_line_oe && brg_tick)
				shift_clock_line_out <= ~shift_clock_line_out;
			transmit_hold <= serial_port_enable & sync_select
				& (continuous_receive_enable | single_receive_enable);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_OVERRUN_STICKY: assert property (overrun_error_flag && continuous_receive_enable
		|=> overrun_error_flag)
		else $error("overrun cleared while receive stayed enabled");
	AST_NO_PUSH_IN_OVERRUN: assert property (overrun_error_flag |-> !push)
		else $error("word pushed while overrun set");
	AST_FULL_GIVES_OVERRUN: assert property (ce && stop_done && fifo_count == 2'h2
		&& continuous_receive_enable |=> overrun_error_flag
		&& fifo_count == 2'h2 - {1'b0, $past(pop)})
		else $error("third word did not raise overrun");
	AST_PUSH_SETS_READY: assert property (ce && push |=> receive_ready_flag ##0 fifo_count != 2'h0)
		else $error("ready flag not set after push");
	AST_IRQ_GATED: assert property (receive_irq |-> $past(irq_enables[`BIT_RX_IRQ_ENABLE])
		&& receive_ready_flag)
		else $error("interrupt without enable or flag");
	AST_READY_TRACKS_FIFO: assert property (receive_ready_flag == (fifo_count != 2'h0))
		else $error("ready flag disagrees with buffer");
	AST_DEPTH_TWO: assert property (fifo_count <= 2'h2)
		else $error("buffer holds more than two");
	AST_DISABLED_GOES_IDLE: assert property (ce && !rx_enable
		|=> rx_state == usart_rx_pkg::RX_IDLE)
		else $error("receiver active while disabled");
	AST_FRAMING_STORED: assert property (ce && push && fifo_count == 2'h0 && !bit_value
		|=> fifo_mem[rd_ptr][9])
		else $error("low stop bit not flagged");
	AST_UPPER_READ_ZERO: assert property ($rose(s_axi_rvalid) |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_MASTER_CLOCK_OE: assert property (ce ##1 ce |-> shift_clock_line_oe
		== $past(serial_port_enable & sync_select & clock_source_master_select))
		else $error("shift clock drive mismatch");

	COV_PUSH: cover property (push);
	COV_FULL: cover property (fifo_count == 2'h2);
	COV_OVERRUN: cover property ($rose(overrun_error_flag));
	COV_NINE_BIT: cover property (push && nine_bit_receive_select);
endmodule
`default_nettype wire

// >>> serial_tx_model.sv
`default_nettype none
module serial_tx_model #(
	parameter int BIT_CLOCKS = 16
) (
	input  wire logic aclk,
	output var  logic line
);
	timeunit 1ns;
	timeprecision 1ns;

	initial line = 1'b1;

	// Start, data LSB first, stop, then one idle bit time high
	task automatic send(input logic [8:0] d, input int nbits, input logic stop, input logic glitch);
		logic b;
		for (int i = 0; i < nbits + 3; i++) begin
			for (int k = 0; k < BIT_CLOCKS; k++) begin
				b = (i == 0) ? 1'b0 : (i <= nbits) ? d[i-1] : (i == nbits + 1) ? stop : 1'b1;
				@(posedge aclk);
				// Optional one-clock spike in the middle of the first data bit
				line <= b ^ (glitch && i == 1 && k == 8);
			end
		end
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk;
	logic        aresetn = 1'b0;
	logic        ce      = 1'b1;
	logic [11:0] awaddr  = 12'h000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [11:0] araddr  = 12'h000;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        awready;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        line;
	logic        clk_out;
	logic        clk_oe;
	logic        hold;
	logic        irq;
	logic [67:0] exp_q[$];
	logic [1:0]  exp_b[$];
	logic [7:0]  d[8];
	logic        c;
	int unsigned seed;
	int          num_errors = 0;
	int          n_compared = 0;

	usart_async_receiver dut_u (
		.aclk                (aclk),
		.aresetn             (aresetn),
		.ce                  (ce),
		.s_axi_awaddr        (awaddr),
		.s_axi_awvalid       (awvalid),
		.s_axi_awready       (awready),
		.s_axi_wdata         (wdata),
		.s_axi_wstrb         (wstrb),
		.s_axi_wvalid        (wvalid),
		.s_axi_wready        (wready),
		.s_axi_bresp         (bresp),
		.s_axi_bvalid        (bvalid),
		.s_axi_bready        (bready),
		.s_axi_araddr        (araddr),
		.s_axi_arvalid       (arvalid),
		.s_axi_arready       (arready),
		.s_axi_rdata         (rdata),
		.s_axi_rresp         (rresp),
		.s_axi_rvalid        (rvalid),
		.s_axi_rready        (rready),
		.serial_data_line_in (line),
		.shift_clock_line_out(clk_out),
		.shift_clock_line_oe (clk_oe),
		.transmit_hold       (hold),
		.receive_irq         (irq)
	);

	serial_tx_model tx_u (
		.aclk(aclk),
		.line(line)
	);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
		input logic [1:0] r = 2'b00);
		bit aw_ok;
		bit w_ok;
		bit b_ok;
		aw_ok = 0;
		w_ok = 0;
		b_ok = 0;
		exp_b.push_back(r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok && b_ok)) begin
			@(posedge aclk);
			if (awready && awvalid) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (wready && wvalid) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
			if (bvalid && bready) begin
				b_ok = 1;
				bready <= 1'b0;
			end
		end
	endtask

	// Note the expected answer, then read; the monitor compares
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m,
		input logic [1:0] r = 2'b00);
		bit r_ok;
		r_ok = 0;
		exp_q.push_back({2'b11, 24'hFFFFFF, m, r, 24'h0, e});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_ok) begin
			@(posedge aclk);
			if (arready && arvalid)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				r_ok = 1;
				rready <= 1'b0;
			end
		end
	endtask

	always @(posedge aclk) begin
		logic [67:0] e;
		if (rvalid && rready) begin
			e = exp_q.pop_front();
			check({rresp, rdata} & e[67:34], e[33:0] & e[67:34]);
		end
		if (bvalid && bready)
			check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
	end

	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		results();
	end

	initial begin
		seed = $urandom(32'h86A74E0A);
		for (int i = 0; i < 8; i++)
			d[i] = 8'($urandom);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h030, 8'h00, 8'hFF);
		rd(12'h060, 8'h00, 8'hFE);
		rd(12'h068, 8'h00, 8'hFF);
		rd(12'h230, 8'h00, 8'hFF);
		rd(12'h260, 8'h02, 8'hFF);
		rd(12'h264, 8'h00, 8'hFF);
		rd(12'h100, 8'h00, 8'hFF, 2'b11);
		wr(12'h800, 8'h00, 4'h1, 2'b11);
		wr(12'h260, 8'hFF, 4'hF);
		rd(12'h260, 8'hF7, 8'hFF);
		wr(12'h264, 8'h55, 4'h0);
		rd(12'h264, 8'h00, 8'hFF);
		wr(12'h260, 8'h04, 4'h1);
		wr(12'h060, 8'h88, 4'h1);
		rd(12'h060, 8'h80, 8'hFE);
		tx_u.send({1'b0, d[0]}, 8, 1'b1, 1'b0);
		rd(12'h030, 8'h00, 8'hFF);
		wr(12'h060, 8'h90, 4'h1);
		tx_u.send({1'b0, d[1]}, 8, 1'b1, 1'b0);
		rd(12'h030, 8'h20, 8'hFF);
		wr(12'h030, 8'h00, 4'h1);
		rd(12'h030, 8'h20, 8'hFF);
		#1;
		check({33'h0, irq}, 34'h0);
		wr(12'h230, 8'h20, 4'h1);
		repeat (2) @(posedge aclk);
		#1;
		check({33'h0, irq}, 34'h1);
		rd(12'h060, 8'h90, 8'hFE);
		rd(12'h068, d[1], 8'hFF);
		rd(12'h030, 8'h00, 8'hFF);
		#1;
		check({33'h0, irq}, 34'h0);
		tx_u.send({1'b0, d[2]}, 8, 1'b1, 1'b1);
		rd(12'h068, d[2], 8'hFF);
		tx_u.send({1'b0, d[3]}, 8, 1'b0, 1'b0);
		tx_u.send({1'b0, d[4]}, 8, 1'b1, 1'b0);
		tx_u.send({1'b0, d[5]}, 8, 1'b1, 1'b0);
		rd(12'h060, 8'h96, 8'hFE);
		rd(12'h068, d[3], 8'hFF);
		rd(12'h060, 8'h92, 8'hFE);
		rd(12'h068, d[4], 8'hFF);
		tx_u.send({1'b0, d[6]}, 8, 1'b1, 1'b0);
		rd(12'h030, 8'h00, 8'hFF);
		wr(12'h060, 8'h80, 4'h1);
		wr(12'h060, 8'h90, 4'h1);
		rd(12'h060, 8'h90, 8'hFA);
		tx_u.send({1'b0, d[7]}, 8, 1'b1, 1'b0);
		rd(12'h068, d[7], 8'hFF);
		wr(12'h060, 8'hD0, 4'h1);
		tx_u.send({1'b1, d[0]}, 9, 1'b1, 1'b0);
		tx_u.send({1'b0, d[1]}, 9, 1'b1, 1'b0);
		rd(12'h060, 8'hD1, 8'hFF);
		rd(12'h068, d[0], 8'hFF);
		rd(12'h060, 8'hD0, 8'hFF);
		rd(12'h068, d[1], 8'hFF);
		wr(12'h260, 8'h90, 4'h1);
		repeat (2) @(posedge aclk);
		#1;
		check({33'h0, clk_oe}, 34'h1);
		check({33'h0, hold}, 34'h1);
		c = clk_out;
		@(posedge aclk);
		#1;
		check({33'h0, c ^ clk_out}, 34'h1);
		// Clock enable low must freeze the shift clock
		@(posedge aclk);
		ce <= 1'b0;
		@(posedge aclk);
		#1;
		c = clk_out;
		repeat (2) @(posedge aclk);
		#1;
		check({33'h0, c ^ clk_out}, 34'h0);
		@(posedge aclk);
		ce <= 1'b1;
		wr(12'h260, 8'h10, 4'h1);
		wr(12'h060, 8'h80, 4'h1);
		repeat (2) @(posedge aclk);
		#1;
		check({33'h0, clk_oe}, 34'h0);
		check({33'h0, hold}, 34'h0);
		repeat (4) @(posedge aclk);
		results();
	end
endmodule
`default_nettype wire
